/* common/accvar_pkg.sv */
// Purpose: shared constants and types of the indexed-variable command unit
// Assumes: one clock, synchronous reset
// Notes:   frame fields are held most significant byte first
`default_nettype none
package accvar_pkg;
  // frame layout
  localparam int          FRAME_BYTES  = 9;
  localparam logic [3:0]  CHK_IDX      = 4'h8;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
  // reply byte positions; the value bytes between them stay zero
  localparam logic [3:0]  REP_HOST_IDX = 4'h0;
  localparam logic [3:0]  REP_MOD_IDX  = 4'h1;
  localparam logic [3:0]  REP_STAT_IDX = 4'h2;
  localparam logic [3:0]  REP_CMD_IDX  = 4'h3;
  // instruction codes
  localparam logic [7:0]  OP_ROT_LEFT  = 8'h32;
  localparam logic [7:0]  OP_ROT_RIGHT = 8'h33;
  localparam logic [7:0]  OP_SET_IVAR  = 8'h37;
  localparam logic [7:0]  OP_GET_IVAR  = 8'h38;
  localparam logic [7:0]  OP_ACC_IVAR  = 8'h39;
  // reply and axis constants
  localparam logic [7:0]  STATUS_OK    = 8'h64;
  localparam logic [7:0]  AP_TGT_VEL   = 8'h02;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam int          VAR_DEPTH    = 256;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  ctype;
    logic [7:0]  motor;
    logic [31:0] value;
  } frame_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  num;
    logic [31:0] data;
  } axis_wr_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_EXEC  = 2'b01,
    S_VEL   = 2'b10,
    S_REPLY = 2'b11
  } state_t;
endpackage
`default_nettype wire

/* logic/accvar_cmd.sv */
// Purpose: executes rotate-by-accumulator and indexed-variable commands
// Assumes: host bytes and program commands arrive on CLK, no resync needed
// Notes:   one command in flight; byte and program ports stall while busy
//          a lost host byte misaligns framing until reset; there is no byte timeout
`default_nettype none
module accvar_cmd
  import accvar_pkg::*;
#(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR   = 8'h02
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_BYTE,
  output var  logic        RX_READY,
  input  wire logic        PROG_VALID,
  input  wire frame_t      PROG_CMD,
  output var  logic        PROG_READY,
  input  wire logic        X_WR,
  input  wire logic [31:0] X_DATA,
  input  wire logic        ACC_WR,
  input  wire logic [31:0] ACC_DATA,
  output var  logic [31:0] ACC,
  output var  logic        VEL_MODE_SET,
  output var  logic        DIR_LEFT,
  output var  axis_wr_t    AXIS_WR,
  output var  logic        TX_VALID,
  output var  logic [7:0]  TX_BYTE,
  input  wire logic        TX_READY
);

  state_t      state_r;
  state_t      state_nxt;
  logic [3:0]  rx_cnt_r;
  logic [63:0] rx_sh_r;
  logic [7:0]  rx_sum_r;
  frame_t      cmd_r;
  logic        direct_r;
  logic [31:0] acc_r;
  logic [31:0] x_r;
  logic        vel_set_r;
  logic        dir_left_r;
  axis_wr_t    axis_r;
  logic        rx_ready_r;
  logic        prog_ready_r;
  logic        tx_valid_r;
  logic [7:0]  tx_byte_r;
  logic [3:0]  tx_cnt_r;
  logic [31:0] var_mem [VAR_DEPTH];

  // byte intake and frame checking
  wire         rx_take    = RX_VALID & rx_ready_r;
  wire         rx_last    = rx_take & (rx_cnt_r == CHK_IDX);
  wire         sum_ok     = (RX_BYTE == rx_sum_r);
  // the first eight bytes seen as a frame, so the address test reads a named field
  wire frame_t rx_frm     = frame_t'(rx_sh_r);
  wire         addr_ok    = (rx_frm.addr == MODULE_ADDR);
  wire         frame_good = rx_last & sum_ok & addr_ok;
  wire         prog_take  = PROG_VALID & prog_ready_r & ~rx_last;
  // a host frame is under way from its first byte until its last
  wire         rx_mid_nxt = ~rx_last & (rx_take | (rx_cnt_r != CNT_ZERO));

  // decode of the held command
  // unknown codes pass through S_EXEC back to idle and change nothing
  wire         is_rol     = (cmd_r.instr == OP_ROT_LEFT);
  wire         is_ror     = (cmd_r.instr == OP_ROT_RIGHT);
  wire         is_siv     = (cmd_r.instr == OP_SET_IVAR);
  wire         is_giv     = (cmd_r.instr == OP_GET_IVAR);
  wire         is_aiv     = (cmd_r.instr == OP_ACC_IVAR);
  wire         is_rot     = is_rol | is_ror;
  wire         is_ivar    = is_siv | is_giv | is_aiv;
  wire         is_known   = is_rot | is_ivar;
  // negative X shows as high bits set, so one test covers both bounds
  wire         x_ok       = (x_r < 32'(VAR_DEPTH));
  wire [7:0]   x_idx      = x_r[7:0];
  wire         in_exec    = (state_r == S_EXEC);
  wire         var_wr     = in_exec & x_ok & (is_siv | is_aiv);
  wire [31:0]  var_wdata  = is_siv ? cmd_r.value : acc_r;
  wire         acc_from_v = in_exec & x_ok & is_giv;
  // read port of the variable array, used only by get-indexed
  wire [31:0]  var_rdata  = var_mem[x_idx];
  // rotate steps: mode and direction at the exec edge, velocity write from S_VEL
  wire         rot_go     = in_exec & is_rot;
  wire         in_vel     = (state_r == S_VEL);
  // a reply starts on entry to S_REPLY, from S_EXEC or from S_VEL
  wire         rep_start  = (state_r != S_REPLY) & (state_nxt == S_REPLY);

  // reply stream: value field carries zeros
  // the value bytes are zero, so only four bytes enter the checksum
  wire [7:0]   rep_sum    = 8'(HOST_ADDR + MODULE_ADDR + STATUS_OK + cmd_r.instr);
  wire         tx_hs      = tx_valid_r & TX_READY;
  wire         tx_end     = tx_hs & (tx_cnt_r == CHK_IDX);
  wire [3:0]   tx_cnt_inc = 4'(tx_cnt_r + CNT_ONE);
  logic [7:0]  rep_byte;

  // byte that follows the one now on offer
  always_comb begin
    case (tx_cnt_inc)
      REP_HOST_IDX: rep_byte = HOST_ADDR;
      REP_MOD_IDX:  rep_byte = MODULE_ADDR;
      REP_STAT_IDX: rep_byte = STATUS_OK;
      REP_CMD_IDX:  rep_byte = cmd_r.instr;
      CHK_IDX:      rep_byte = rep_sum;
      default:      rep_byte = BYTE_ZERO;
    endcase
  end

  // next state
  // program commands never reply, so they skip S_REPLY
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (frame_good | prog_take) begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (is_rot) begin
          state_nxt = S_VEL;
        end else if (is_ivar & direct_r) begin
          state_nxt = S_REPLY;
        end else begin
          state_nxt = S_IDLE;
        end
      end
      S_VEL: begin
        state_nxt = direct_r ? S_REPLY : S_IDLE;
      end
      S_REPLY: begin
        if (tx_end) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // frame assembly, running byte sum of the first eight bytes
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_cnt_r <= CNT_ZERO;
      rx_sh_r  <= 64'h0;
      rx_sum_r <= BYTE_ZERO;
    end else if (rx_last) begin
      rx_cnt_r <= CNT_ZERO;
      rx_sum_r <= BYTE_ZERO;
    end else if (rx_take) begin
      rx_cnt_r <= 4'(rx_cnt_r + CNT_ONE);
      rx_sh_r  <= {rx_sh_r[55:0], RX_BYTE};
      rx_sum_r <= 8'(rx_sum_r + RX_BYTE);
    end
  end

  // intake readiness: the byte port stays open mid-frame, closes while busy
  // the program port waits out a host frame from its second byte on; a command taken with the first byte runs mid-frame
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_ready_r   <= 1'b0;
      prog_ready_r <= 1'b0;
    end else begin
      rx_ready_r   <= (state_nxt == S_IDLE);
      prog_ready_r <= (state_nxt == S_IDLE) & ~rx_mid_nxt;
    end
  end

  // command capture; a good host frame wins over a program command
  // the program port drops at once, so the losing command is simply offered again
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_r    <= frame_t'(64'h0);
      direct_r <= 1'b0;
    end else if (frame_good) begin
      cmd_r    <= rx_frm;
      direct_r <= 1'b1;
    end else if (prog_take) begin
      cmd_r    <= PROG_CMD;
      direct_r <= 1'b0;
    end
  end

  // X register, loaded by the surrounding interpreter
  // it is signed; a negative value reads as out of range
  always_ff @(posedge CLK) begin
    if (RST) begin
      x_r <= WORD_ZERO;
    end else if (X_WR) begin
      x_r <= X_DATA;
    end
  end

  // accumulator: a get-indexed load beats an outside load in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      acc_r <= WORD_ZERO;
    end else if (acc_from_v) begin
      acc_r <= var_rdata;
    end else if (ACC_WR) begin
      acc_r <= ACC_DATA;
    end
  end

  // user variables; no reset, contents are undefined until written
  // one command runs at a time, so a write and a read never meet on one index
  always_ff @(posedge CLK) begin
    if (var_wr) begin
      var_mem[x_idx] <= var_wdata;
    end
  end

  // mode select pulse; the axis must be in velocity mode before the target lands
  always_ff @(posedge CLK) begin
    if (RST) begin
      vel_set_r <= 1'b0;
    end else begin
      vel_set_r <= rot_go;
    end
  end

  // direction is a level, held between rotates so the axis keeps its sense
  always_ff @(posedge CLK) begin
    if (RST) begin
      dir_left_r <= 1'b0;
    end else if (rot_go) begin
      dir_left_r <= is_rol;
    end
  end

  // target velocity write one cycle after the mode pulse
  always_ff @(posedge CLK) begin
    if (RST) begin
      axis_r <= axis_wr_t'(41'h0);
    end else begin
      axis_r.wr <= in_vel;
      if (in_vel) begin
        axis_r.num  <= AP_TGT_VEL;
        axis_r.data <= acc_r;
      end
    end
  end

  // reply valid, only for host frames: up until the checksum byte is taken
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_valid_r <= 1'b0;
    end else if (rep_start) begin
      tx_valid_r <= 1'b1;
    end else if (tx_end) begin
      tx_valid_r <= 1'b0;
    end
  end

  // reply byte and position; a stalled byte stays put until the sink takes it
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_byte_r <= BYTE_ZERO;
      tx_cnt_r  <= CNT_ZERO;
    end else if (rep_start) begin
      tx_byte_r <= HOST_ADDR;
      tx_cnt_r  <= CNT_ZERO;
    end else if (tx_hs & ~tx_end) begin
      tx_byte_r <= rep_byte;
      tx_cnt_r  <= tx_cnt_inc;
    end
  end

  // outputs straight from flops
  assign RX_READY     = rx_ready_r;
  assign PROG_READY   = prog_ready_r;
  assign ACC          = acc_r;
  assign VEL_MODE_SET = vel_set_r;
  assign DIR_LEFT     = dir_left_r;
  assign AXIS_WR      = axis_r;
  assign TX_VALID     = tx_valid_r;
  assign TX_BYTE      = tx_byte_r;

endmodule // accvar_cmd
`default_nettype wire

/* tb/accvar_cmd_asserts.sv */
// Purpose: port assertions of the command unit
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design from the bench top
`default_nettype none
module accvar_cmd_asserts
  import accvar_pkg::*;
#(
  parameter logic [7:0] HOST_ADDR = 8'h02
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        RX_READY,
  input wire logic        PROG_READY,
  input wire logic        VEL_MODE_SET,
  input wire logic [31:0] ACC,
  input wire axis_wr_t    AXIS_WR,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_BYTE,
  input wire logic        TX_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // the two steps of a rotate: mode first, then the velocity write
  sequence mode_step;
    VEL_MODE_SET;
  endsequence
  sequence vel_step;
    AXIS_WR.wr && AXIS_WR.num == AP_TGT_VEL && AXIS_WR.data == ACC;
  endsequence
  a_mode_then_vel: assert property (mode_step |=> vel_step)
    else $error("velocity write did not follow mode select");
  a_vel_after_mode: assert property (AXIS_WR.wr |-> $past(VEL_MODE_SET))
    else $error("velocity write without mode select");
  a_mode_one_pulse: assert property (VEL_MODE_SET |=> !VEL_MODE_SET)
    else $error("mode select longer than one cycle");
  a_no_mode_open: assert property (VEL_MODE_SET |-> !RX_READY)
    else $error("mode select while byte port open");
  // ports open exactly one edge after reset is released
  a_reset_ready: assert property ($fell(RST) |-> !RX_READY && !PROG_READY ##1 RX_READY && PROG_READY)
    else $error("ports not opened after reset");
  a_reply_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE))
    else $error("reply byte changed while stalled");
  a_reply_to_host: assert property ($rose(TX_VALID) |-> TX_BYTE == HOST_ADDR)
    else $error("reply does not start with host address");
  a_busy_in_reply: assert property (TX_VALID |-> !RX_READY)
    else $error("byte port open during reply");
endmodule // accvar_cmd_asserts
`default_nettype wire

/* tb/host_model.sv */
// Purpose: host side model, sends frames and sinks replies
// Assumes: bytes change at the falling edge only
// Notes:   sink stalls every other cycle when slow is set
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       slow,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_byte,
  output var  logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] reply_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // stalling sink; replies kept for the bench to judge
  always @(negedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk) if (tx_valid && tx_ready) reply_q.push_back(tx_byte);
  // bytes held until taken; released byte is inverted so nothing stale looks valid
  task automatic send(logic [71:0] f);
    for (int i = 8; i >= 0; i--) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = f[i*8 +: 8];
      while (!rx_ready) @(negedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
endmodule // host_model
`default_nettype wire

/* tb/accvar_cmd_test.sv */
// Purpose: self-checking bench of the command unit
// Assumes: host model sends bytes; bench drives the rest at falling edges
// Notes:   variable array has no reset, so every read follows a write
`default_nettype none
module accvar_cmd_test;
  timeunit 1ns;
  timeprecision 1ps;
  import accvar_pkg::*;
  logic        clk, rst, rx_valid, rx_ready, prog_valid, prog_ready, x_wr, acc_wr, vms, dir_left;
  logic        tx_valid, tx_ready, slow, dir_seen;
  logic [7:0]  rx_byte, tx_byte;
  logic [31:0] x_data, acc_data, acc, a, b, vel_seen, s = 32'h0000_0055;
  logic [31:0] bad [2] = '{32'h0000_0100, 32'hffff_ffff};
  frame_t      prog_cmd;
  axis_wr_t    axis_wr;
  int          failures = 0, comparisons = 0, cycles = 0;
  accvar_cmd dut (.CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_READY(rx_ready),
    .PROG_VALID(prog_valid), .PROG_CMD(prog_cmd), .PROG_READY(prog_ready), .X_WR(x_wr), .X_DATA(x_data),
    .ACC_WR(acc_wr), .ACC_DATA(acc_data), .ACC(acc), .VEL_MODE_SET(vms), .DIR_LEFT(dir_left),
    .AXIS_WR(axis_wr), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .TX_READY(tx_ready));
  host_model host (.clk, .rx_ready, .tx_valid, .tx_byte, .slow, .rx_valid, .rx_byte, .tx_ready);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // velocity writes seen at the axis, and a hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (axis_wr.wr) begin
      vel_seen <= axis_wr.data;
      dir_seen <= dir_left;
    end
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // frame with byte-sum checksum appended
  function automatic logic [71:0] frm(logic [7:0] p, logic [7:0] q, logic [7:0] t, logic [7:0] m, logic [31:0] v);
    logic [7:0] c;
    c = p + q + t + m + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    return {p, q, t, m, v, c};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic setreg(logic to_x, logic [31:0] d);
    @(negedge clk);
    if (to_x) begin
      x_wr = 1'b1;
      x_data = d;
    end else begin
      acc_wr = 1'b1;
      acc_data = d;
    end
    @(negedge clk);
    x_wr = 1'b0;
    acc_wr = 1'b0;
  endtask
  // send a host frame, then judge the reply (or its absence)
  task automatic cmd(logic [71:0] f, logic ok);
    logic [71:0] r;
    int n;
    r = frm(8'h02, 8'h01, STATUS_OK, f[63:56], 32'h0);
    host.send(f);
    for (n = 0; n < 60 && host.reply_q.size() < 9; n++) @(negedge clk);
    chk("replies", ok ? 32'h9 : 32'h0, host.reply_q.size());
    for (int i = 0; i < 9 && ok; i++) chk("reply", r[8*(8-i) +: 8], host.reply_q[i]);
    host.reply_q.delete();
  endtask
  task automatic prog(frame_t c);
    @(negedge clk);
    prog_valid = 1'b1;
    prog_cmd = c;
    while (!prog_ready) @(negedge clk);
    @(negedge clk);
    prog_valid = 1'b0;
    prog_cmd = ~c;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    rst = 1'b1;
    {x_wr, acc_wr, prog_valid, slow} = 4'h0;
    {x_data, acc_data} = 64'h0;
    prog_cmd = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    // rotate both ways, example frames then random don't-care fields
    for (int k = 0; k < 3; k++) begin
      a = rnd();
      setreg(1'b0, a);
      slow = k[0];
      cmd(k == 0 ? 72'h01_32_00_00_00000000_33 : k == 1 ? 72'h01_33_00_00_00000000_34
          : frm(8'h01, OP_ROT_RIGHT, a[7:0], a[15:8], rnd()), 1'b1);
      chk("velocity", a, vel_seen);
      chk("left", {31'h0, k == 0}, {31'h0, dir_seen});
    end
    // indexed commands at a random index
    a = rnd();
    setreg(1'b1, {24'h0, a[7:0]});
    cmd(72'h01_37_00_00_00000003_3b, 1'b1);
    setreg(1'b0, rnd());
    cmd(72'h01_38_00_00_00000000_39, 1'b1);
    chk("get", 32'h3, acc);
    b = rnd();
    setreg(1'b0, b);
    cmd(72'h01_39_00_00_00000000_3a, 1'b1);
    setreg(1'b0, rnd());
    cmd(frm(8'h01, OP_GET_IVAR, 8'h00, 8'h00, rnd()), 1'b1);
    chk("stored acc", b, acc);
    cmd(frm(8'h01, 8'h40, 8'h00, 8'h00, rnd()), 1'b0);
    // out-of-range index and dropped frames leave everything alone
    foreach (bad[i]) begin
      b = rnd();
      setreg(1'b1, {24'h0, bad[i][7:0]});
      cmd(frm(8'h01, OP_SET_IVAR, 8'h00, 8'h00, b), 1'b1);
      setreg(1'b1, bad[i]);
      cmd(frm(8'h01, OP_SET_IVAR, 8'h00, 8'h00, ~b), 1'b1);
      cmd(72'h01_39_00_00_00000000_3a, 1'b1);
      a = rnd();
      setreg(1'b0, a);
      cmd(72'h01_38_00_00_00000000_39, 1'b1);
      chk("acc kept", a, acc);
      setreg(1'b1, {24'h0, bad[i][7:0]});
      cmd(frm(8'h01, OP_SET_IVAR, 8'h00, 8'h00, ~b) ^ 72'h1, 1'b0);
      cmd(frm(8'h05, OP_SET_IVAR, 8'h00, 8'h00, ~b), 1'b0);
      cmd(72'h01_38_00_00_00000000_39, 1'b1);
      chk("var kept", b, acc);
    end
    // reset in mid-run: accumulator and X clear, ports reopen
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("acc reset", 32'h0, acc);
    // stored-program path, no reply expected
    a = rnd();
    prog({a[15:8], OP_SET_IVAR, 16'h0, a});
    setreg(1'b0, rnd());
    prog({a[23:16], OP_GET_IVAR, 16'h0, 32'h0});
    chk("prog get", a, acc);
    chk("prog reply", 32'h0, host.reply_q.size());
    a = rnd();
    setreg(1'b0, a);
    prog({8'h00, OP_ROT_LEFT, 16'h0, 32'h0});
    chk("prog velocity", a, vel_seen);
    chk("prog left", 32'h1, {31'h0, dir_seen});
    chk("prog rot reply", 32'h0, host.reply_q.size());
    stop_test();
  end
endmodule // accvar_cmd_test
bind accvar_cmd accvar_cmd_asserts #(.HOST_ADDR(HOST_ADDR)) props (.CLK, .RST, .RX_READY, .PROG_READY,
  .VEL_MODE_SET, .ACC, .AXIS_WR, .TX_VALID, .TX_BYTE, .TX_READY);
`default_nettype wire
